// ===== hw/tcf_pkg.sv
// Constants, encodings and helpers of the text command frame parser.
// Assumes one clock domain and 8-bit characters on both streams.
// How it works
// - Each accepted command frame produces exactly one response frame.
// - After reset an announcement frame goes out before any command.
// - Protocol characters compare exactly, case distinct; hex digits of tag and check accept either case.
// - Frame is brace, name, optional tag, arguments, optional check, brace.
// - A two-digit tag from 01 to FF is echoed in the response.
// - Each argument follows a comma; quoted arguments may hold punctuation.
// - Quoted escapes map r, n, t, backslash; others drop the backslash.
// - Command check is XOR of characters between brace and bar, two hex.
// - Check mismatch answers with error code 3.
// - Badly formed frames answer with an error response, not a normal one.
// - Response is bracket, optional tag, equals or bang, value, optional check.
// - Response value is cut at 4096 characters.
// - Response ends with right bracket, carriage return, line feed.
// - Response check appears only when the command carried one.
// - Response check is XOR of characters between bracket and bar.
// - Syntax error is code 1; too few arguments code 2 from executor.
package tcf_pkg;
   localparam logic [7:0] CH_LBRACE = 8'h7b;
   localparam logic [7:0] CH_RBRACE = 8'h7d;
   localparam logic [7:0] CH_LBRK   = 8'h5b;
   localparam logic [7:0] CH_RBRK   = 8'h5d;
   localparam logic [7:0] CH_HASH   = 8'h23;
   localparam logic [7:0] CH_COMMA  = 8'h2c;
   localparam logic [7:0] CH_BAR    = 8'h7c;
   localparam logic [7:0] CH_QUOTE  = 8'h22;
   localparam logic [7:0] CH_BSL    = 8'h5c;
   localparam logic [7:0] CH_EQ     = 8'h3d;
   localparam logic [7:0] CH_BANG   = 8'h21;
   localparam logic [7:0] CH_GT     = 8'h3e;
   localparam logic [7:0] CH_CR     = 8'h0d;
   localparam logic [7:0] CH_LF     = 8'h0a;
   localparam logic [7:0] CH_TAB    = 8'h09;
   localparam logic [7:0] CH_SP     = 8'h20;
   localparam logic [7:0] CH_R      = 8'h72;
   localparam logic [7:0] CH_N      = 8'h6e;
   localparam logic [7:0] CH_T      = 8'h74;
   localparam logic [7:0] ERR_SYNTAX = 8'h31;
   localparam logic [7:0] ERR_CHECK  = 8'h33;
   localparam logic [12:0] VALUE_MAX = 13'h1000;
   localparam int FIFO_DEPTH = 4;
   localparam int CHAR_W     = 8;
   // Announcement text, last character in the top byte
   localparam logic [39:0] ANN_TEXT = 40'h7964616552;
   localparam logic [2:0]  ANN_LAST = 3'h4;
   localparam logic [1:0] KIND_NAME = 2'h0;
   localparam logic [1:0] KIND_ARG  = 2'h1;
   localparam logic [1:0] KIND_SEP  = 2'h2;

   typedef enum logic [13:0] {
      P_IDLE = 14'h0001, P_NAME0 = 14'h0002, P_NAME = 14'h0004,
      P_TAG1 = 14'h0008, P_TAG2 = 14'h0010, P_POST = 14'h0020,
      P_ARG0 = 14'h0040, P_ARG = 14'h0080, P_QUOTE = 14'h0100,
      P_ESC = 14'h0200, P_CK1 = 14'h0400, P_CK2 = 14'h0800,
      P_CKEND = 14'h1000, P_BAD = 14'h2000
   } tcf_pstate_e;

   typedef enum logic [11:0] {
      E_OPEN = 12'h001, E_HASH = 12'h002, E_TAGH = 12'h004,
      E_TAGL = 12'h008, E_TYPE = 12'h010, E_VAL = 12'h020,
      E_BAR = 12'h040, E_CKH = 12'h080, E_CKL = 12'h100,
      E_CLOSE = 12'h200, E_CR = 12'h400, E_LF = 12'h800
   } tcf_step_e;

   typedef enum logic [2:0] {
      PH_ANN = 3'h1, PH_PARSE = 3'h2, PH_RESP = 3'h4
   } tcf_phase_e;

   // Returns {ok, nibble}
   function automatic logic [4:0] tcf_hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
      if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
         return {1'b1, c[3:0] + 4'h9};
      return 5'h00;
   endfunction

   function automatic logic [7:0] tcf_hex_char(input logic [3:0] n);
      return (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
   endfunction
endpackage

// ===== hw/tcf_parser.sv
// Command frame parser, response framer and output FIFO.
// Assumes rx and tx character streams on the same clock as the block.
// ----------------------------------------------------------------
// Shift-register FIFO, head word always in a flip-flop
// ----------------------------------------------------------------
module tcf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   logic [DEPTH*WIDTH-1:0] mem_reg;
   logic [DEPTH*WIDTH-1:0] mem_shift;
   logic [DEPTH*WIDTH-1:0] mem_next;
   logic [DEPTH-1:0]       vld_reg;
   logic [DEPTH-1:0]       vld_shift;
   logic [DEPTH-1:0]       vld_next;
   logic [DEPTH-1:0]       wr_sel;
   wire                    pop  = out_valid && out_ready;
   wire                    push = in_valid && in_ready;

   assign in_ready  = !vld_reg[DEPTH-1];
   assign out_valid = vld_reg[0];
   assign out_data  = mem_reg[WIDTH-1:0];
   assign vld_shift = pop ? {1'b0, vld_reg[DEPTH-1:1]} : vld_reg;
   assign vld_next  = push ? {vld_shift[DEPTH-2:0], 1'b1} : vld_shift;
   assign wr_sel    = {vld_shift[DEPTH-2:0], 1'b1} & ~vld_shift;
   assign mem_shift = pop ? {{WIDTH{1'b0}}, mem_reg[DEPTH*WIDTH-1:WIDTH]}
                          : mem_reg;

   always_comb begin
      mem_next = mem_shift;
      for (int i = 0; i < DEPTH; i++) begin
         if (push && wr_sel[i]) mem_next[i*WIDTH +: WIDTH] = in_data;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mem_reg <= '0;
         vld_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         vld_reg <= vld_next;
      end
   end
endmodule

// ----------------------------------------------------------------
// Top: parser, response framer
// ----------------------------------------------------------------
module tcf_parser (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic [7:0] rx_data,
   input  wire logic       rx_valid,
   output logic            rx_ready,
   output logic            cmd_start,
   output logic            cmd_valid,
   output logic [7:0]      cmd_data,
   output logic [1:0]      cmd_kind,
   output logic            cmd_go,
   input  wire logic [7:0] ans_data,
   input  wire logic       ans_valid,
   input  wire logic       ans_error,
   input  wire logic       ans_last,
   output logic            ans_ready,
   output logic [7:0]      tx_data,
   output logic            tx_valid,
   input  wire logic       tx_ready
);
   import tcf_pkg::*;

   tcf_pstate_e pstate_reg, p_next;
   tcf_step_e   step_reg, s_next, s_to;
   tcf_phase_e  phase_reg, ph_next;
   logic [7:0]  xor_reg, tag_reg, ck_reg, rxor_reg, code_reg;
   logic        has_tag_reg, has_ck_reg, src_int_reg;
   logic [12:0] vcount_reg;
   logic        rx_ready_reg, ans_ready_reg;
   logic        cmd_start_reg, cmd_valid_reg, cmd_go_reg;
   logic [7:0]  cmd_data_reg, fdata, e_char;
   logic [1:0]  cmd_kind_reg, fkind;
   logic        fwd, bad, tail, end_good, end_err1, end_chk;
   logic        tag_hi, tag_lo, ck_hi, ck_lo;
   logic        go, last, e_push, e_done, f_rdy;

   wire [7:0] c        = rx_data;
   wire       rx_take  = rx_valid && rx_ready_reg;
   wire [4:0] hx       = tcf_hex_val(c);
   wire       hx_ok    = hx[4];
   wire       is_sep   = c == CH_COMMA;
   wire       is_bar   = c == CH_BAR;
   wire       is_end   = c == CH_RBRACE;
   wire       tail_ch  = is_sep || is_bar || is_end;
   wire       quoted   = pstate_reg == P_QUOTE || pstate_reg == P_ESC;
   wire       restart  = c == CH_LBRACE && !quoted;
   wire [7:0] esc_char = c == CH_R ? CH_CR : c == CH_N ? CH_LF
                       : c == CH_T ? CH_TAB : c;
   wire       ck_ok    = ck_reg == xor_reg;
   wire       frame_good = end_good || (end_chk && ck_ok);
   wire       frame_bad  = end_err1 || (end_chk && !ck_ok);
   wire       frame_end  = frame_good || frame_bad;
   wire       xor_on   = rx_take && !restart && p_next != P_CK1 &&
                         (pstate_reg & (P_IDLE | P_CK1 | P_CK2 | P_CKEND))
                         == 14'h0000;
   wire       ann      = phase_reg == PH_ANN;
   wire       ans_take = ans_valid && ans_ready_reg;
   wire       exec_val = step_reg == E_VAL && !ann && !src_int_reg;
   wire       vlimit   = vcount_reg == VALUE_MAX;
   wire       drop     = exec_val && vlimit;
   wire       rx_step  = (step_reg & (E_HASH | E_TAGH | E_TAGL | E_TYPE
                         | E_VAL)) != 12'h000;
   wire [7:0] ann_char = ANN_TEXT[vcount_reg[2:0]*8 +: 8];

   // ----------------------------------------------------------------
   // Parser next state
   // ----------------------------------------------------------------
   always_comb begin
      p_next = pstate_reg;
      fwd = 1'b0;
      fkind = KIND_NAME;
      fdata = c;
      bad = 1'b0;
      tail = 1'b0;
      end_good = 1'b0;
      end_err1 = 1'b0;
      end_chk = 1'b0;
      tag_hi = 1'b0;
      tag_lo = 1'b0;
      ck_hi = 1'b0;
      ck_lo = 1'b0;
      if (rx_take && restart) begin
         p_next = P_NAME0;
      end else if (rx_take) begin
         case (pstate_reg)
            P_IDLE: p_next = P_IDLE;
            P_NAME0: begin
               if (tail_ch || c == CH_HASH || c == CH_SP || c == CH_QUOTE)
                  bad = 1'b1;
               else begin
                  fwd = 1'b1;
                  p_next = P_NAME;
               end
            end
            P_NAME: begin
               if (tail_ch) tail = 1'b1;
               else if (c == CH_HASH) p_next = P_TAG1;
               else if (c == CH_SP || c == CH_QUOTE) bad = 1'b1;
               else fwd = 1'b1;
            end
            P_TAG1: begin
               tag_hi = hx_ok;
               p_next = P_TAG2;
               bad = !hx_ok;
            end
            P_TAG2: begin
               tag_lo = hx_ok && {tag_reg[7:4], hx[3:0]} != 8'h00;
               p_next = P_POST;
               bad = !tag_lo;
            end
            P_POST: begin
               tail = tail_ch;
               bad = !tail_ch;
            end
            P_ARG0, P_ARG: begin
               if (tail_ch) tail = 1'b1;
               else if (c == CH_QUOTE && pstate_reg == P_ARG0)
                  p_next = P_QUOTE;
               else if (c == CH_SP || c == CH_HASH || c == CH_QUOTE)
                  bad = 1'b1;
               else begin
                  fwd = 1'b1;
                  fkind = KIND_ARG;
                  p_next = P_ARG;
               end
            end
            P_QUOTE: begin
               if (c == CH_QUOTE) p_next = P_POST;
               else if (c == CH_BSL) p_next = P_ESC;
               else begin
                  fwd = 1'b1;
                  fkind = KIND_ARG;
               end
            end
            P_ESC: begin
               fwd = 1'b1;
               fkind = KIND_ARG;
               fdata = esc_char;
               p_next = P_QUOTE;
            end
            P_CK1: begin
               ck_hi = hx_ok;
               p_next = P_CK2;
               bad = !hx_ok;
            end
            P_CK2: begin
               ck_lo = hx_ok;
               p_next = P_CKEND;
               bad = !hx_ok;
            end
            P_CKEND: begin
               end_chk = is_end;
               bad = !is_end;
            end
            P_BAD: bad = 1'b1;
            default: p_next = P_IDLE;
         endcase
         if (tail) begin
            if (is_sep) begin
               fwd = 1'b1;
               fkind = KIND_SEP;
               p_next = P_ARG0;
            end else if (is_bar) p_next = P_CK1;
            else end_good = 1'b1;
         end
         if (bad) begin
            if (is_end) end_err1 = 1'b1;
            else p_next = P_BAD;
         end
         if (end_good || end_err1 || end_chk) p_next = P_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // Response and announcement framer
   // ----------------------------------------------------------------
   always_comb begin
      s_to = step_reg;
      go = f_rdy;
      last = 1'b1;
      e_char = CH_LBRK;
      case (step_reg)
         E_OPEN: s_to = (has_tag_reg && !ann) ? E_HASH : E_TYPE;
         E_HASH: begin
            e_char = CH_HASH;
            s_to = E_TAGH;
         end
         E_TAGH: begin
            e_char = tcf_hex_char(tag_reg[7:4]);
            s_to = E_TAGL;
         end
         E_TAGL: begin
            e_char = tcf_hex_char(tag_reg[3:0]);
            s_to = E_TYPE;
         end
         E_TYPE: begin
            e_char = ann ? CH_GT : (src_int_reg || ans_error) ? CH_BANG
                   : CH_EQ;
            go = f_rdy && (ann || src_int_reg || ans_valid);
            s_to = E_VAL;
         end
         E_VAL: begin
            if (ann) begin
               e_char = ann_char;
               last = vcount_reg[2:0] == ANN_LAST;
            end else if (src_int_reg) e_char = code_reg;
            else begin
               e_char = ans_data;
               go = ans_take;
               last = ans_last;
            end
            s_to = !last ? E_VAL
                 : (has_ck_reg && !ann) ? E_BAR : E_CLOSE;
         end
         E_BAR: begin
            e_char = CH_BAR;
            s_to = E_CKH;
         end
         E_CKH: begin
            e_char = tcf_hex_char(rxor_reg[7:4]);
            s_to = E_CKL;
         end
         E_CKL: begin
            e_char = tcf_hex_char(rxor_reg[3:0]);
            s_to = E_CLOSE;
         end
         E_CLOSE: begin
            e_char = CH_RBRK;
            s_to = E_CR;
         end
         E_CR: begin
            e_char = CH_CR;
            s_to = E_LF;
         end
         E_LF: begin
            e_char = CH_LF;
            s_to = E_OPEN;
         end
         default: s_to = E_OPEN;
      endcase
      go = go && !(phase_reg == PH_PARSE);
      e_push = go && !drop;
      s_next = go ? s_to : step_reg;
      e_done = go && step_reg == E_LF;
   end

   always_comb begin
      ph_next = phase_reg;
      case (phase_reg)
         PH_ANN: if (e_done) ph_next = PH_PARSE;
         PH_PARSE: if (frame_end) ph_next = PH_RESP;
         PH_RESP: if (e_done) ph_next = PH_PARSE;
         default: ph_next = PH_ANN;
      endcase
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pstate_reg <= P_IDLE;
         xor_reg <= 8'h00;
         tag_reg <= 8'h00;
         ck_reg <= 8'h00;
         has_tag_reg <= 1'b0;
         has_ck_reg <= 1'b0;
      end else begin
         pstate_reg <= p_next;
         if (rx_take && restart) xor_reg <= 8'h00;
         else if (xor_on) xor_reg <= xor_reg ^ c;
         if (tag_hi) tag_reg[7:4] <= hx[3:0];
         if (tag_lo) tag_reg[3:0] <= hx[3:0];
         if (ck_hi) ck_reg[7:4] <= hx[3:0];
         if (ck_lo) ck_reg[3:0] <= hx[3:0];
         if (rx_take && restart) has_tag_reg <= 1'b0;
         else if (tag_lo) has_tag_reg <= 1'b1;
         if (rx_take && restart) has_ck_reg <= 1'b0;
         else if (tail && is_bar) has_ck_reg <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phase_reg <= PH_ANN;
         step_reg <= E_OPEN;
         rxor_reg <= 8'h00;
         vcount_reg <= 13'h0000;
         src_int_reg <= 1'b0;
         code_reg <= ERR_SYNTAX;
      end else begin
         phase_reg <= ph_next;
         step_reg <= s_next;
         if (go && step_reg == E_OPEN) rxor_reg <= 8'h00;
         else if (e_push && rx_step) rxor_reg <= rxor_reg ^ e_char;
         if (go && step_reg == E_OPEN) vcount_reg <= 13'h0000;
         else if (go && step_reg == E_VAL && !vlimit)
            vcount_reg <= vcount_reg + 13'h0001;
         if (frame_end) src_int_reg <= frame_bad;
         if (frame_end) code_reg <= end_err1 ? ERR_SYNTAX : ERR_CHECK;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rx_ready_reg <= 1'b0;
         ans_ready_reg <= 1'b0;
         cmd_start_reg <= 1'b0;
         cmd_valid_reg <= 1'b0;
         cmd_data_reg <= 8'h00;
         cmd_kind_reg <= KIND_NAME;
         cmd_go_reg <= 1'b0;
      end else begin
         rx_ready_reg <= ph_next == PH_PARSE;
         // One free FIFO slot is certain when ready rises
         ans_ready_reg <= ph_next == PH_RESP && s_next == E_VAL &&
                          !src_int_reg && !ans_take && !e_push && f_rdy;
         cmd_start_reg <= rx_take && restart;
         cmd_valid_reg <= fwd;
         cmd_data_reg <= fdata;
         cmd_kind_reg <= fkind;
         cmd_go_reg <= frame_good;
      end
   end

   assign rx_ready  = rx_ready_reg;
   assign ans_ready = ans_ready_reg;
   assign cmd_start = cmd_start_reg;
   assign cmd_valid = cmd_valid_reg;
   assign cmd_data  = cmd_data_reg;
   assign cmd_kind  = cmd_kind_reg;
   assign cmd_go    = cmd_go_reg;

   tcf_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .reset_n   (reset_n),
      .in_data   (e_char),
      .in_valid  (e_push),
      .in_ready  (f_rdy),
      .out_data  (tx_data),
      .out_valid (tx_valid),
      .out_ready (tx_ready)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_one_resp: assert property (frame_end |=> phase_reg == PH_RESP &&
      !rx_ready_reg) else $error("no response phase after frame");
   a_ann_type: assert property (ann && go && step_reg == E_TYPE |->
      e_char == CH_GT) else $error("announcement type wrong");
   a_tag_echo: assert property (e_push && step_reg == E_TAGH |->
      has_tag_reg && tag_reg != 8'h00 ##1 step_reg == E_TAGL)
      else $error("tag echo wrong");
   a_space_bad: assert property (rx_take && c == CH_SP &&
      (pstate_reg == P_NAME || pstate_reg == P_ARG) |=> pstate_reg == P_BAD)
      else $error("space accepted");
   a_esc_map: assert property (rx_take && pstate_reg == P_ESC &&
      c == CH_N |=> cmd_valid_reg && cmd_data_reg == CH_LF)
      else $error("escape not mapped");
   a_bad_check: assert property (rx_take && pstate_reg == P_CKEND &&
      is_end && ck_reg != xor_reg |=> src_int_reg && code_reg == ERR_CHECK)
      else $error("checksum error not raised");
   a_syntax_err: assert property (rx_take && pstate_reg == P_BAD &&
      is_end |=> src_int_reg && code_reg == ERR_SYNTAX && !cmd_go_reg)
      else $error("syntax error not raised");
   a_crlf_end: assert property (e_push && step_reg == E_CR |->
      e_char == CH_CR ##1 step_reg == E_LF) else $error("bad frame tail");
   a_ck_omit: assert property (phase_reg == PH_RESP && !has_ck_reg |->
      step_reg != E_BAR && step_reg != E_CKH) else $error("stray check");
   a_restart: assert property (rx_take && restart |=>
      pstate_reg == P_NAME0 && cmd_start_reg && xor_reg == 8'h00)
      else $error("restart failed");
   a_fifo_room: assert property (e_push |-> f_rdy)
      else $error("push into full fifo");

   c_good_ck: cover property (end_chk && ck_ok);
   c_bad_ck: cover property (end_chk && !ck_ok);
   c_ann_done: cover property (ann && e_done);
   c_restart: cover property (rx_take && restart && pstate_reg == P_ARG);
endmodule

// ===== tb/tcf_exec_model.sv
// Command executor model on the answer side of the frame parser.
// Assumes the parser's clock; answers every go pulse with value "42".
module tcf_exec_model (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       cmd_go,
   input  wire logic       ans_ready,
   output logic [7:0]      ans_data,
   output logic            ans_valid,
   output logic            ans_error,
   output logic            ans_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic idx_reg;
   // -----------------
   // Answer sequencer
   // -----------------
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         idx_reg   <= 1'b0;
         ans_valid <= 1'b0;
      end else if (cmd_go) begin
         idx_reg   <= 1'b0;
         ans_valid <= 1'b1;
      end else if (ans_valid && ans_ready) begin
         idx_reg <= 1'b1;
         if (ans_last) begin
            ans_valid <= 1'b0;
         end
      end
   end
   // Idle data shows a moving pattern, not the last character
   assign ans_data  = ans_valid ? (idx_reg ? 8'h32 : 8'h34) : {7'h55, clock};
   assign ans_last  = idx_reg;
   assign ans_error = 1'b0;
endmodule

// ===== tb/text_command_frame_parser_tb.sv
// Self-checking bench of the frame parser with the executor model.
// Assumes the single clock domain; response bytes checked in order.
module text_command_frame_parser_tb;
   import tcf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock, reset_n, rx_valid, rx_ready, cmd_start, cmd_valid;
   logic       cmd_go, ans_valid, ans_error, ans_last, ans_ready;
   logic       tx_valid, tx_ready;
   logic [7:0] rx_data, cmd_data, ans_data, tx_data;
   logic [1:0] cmd_kind;
   logic [7:0] q[$];
   logic [7:0] aq[$];
   int         n_errors, comparisons, cycles;
   int         n_go, n_start, n_cmd;
   // Expected executor stream: characters and their kinds, in order
   string      names = "ababababaxabab,x\tqab";
   string      kinds = "00000000000000211100";
   string      cmds[7] = '{"{ab}", "{ab#ff}", "{ab#3c|70}", "{ab|04}",
                           "{a b}", "{x{ab}", "{ab,\"x\\t\\q\"}"};
   string      resp[7] = '{"[=42]", "[#FF=42]", "[#3C=42|68]", "[!3|12]",
                           "[!1]", "[=42]", "[=42]"};
   tcf_parser uut (.clock(clock), .reset_n(reset_n), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .cmd_start(cmd_start),
      .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_kind(cmd_kind),
      .cmd_go(cmd_go), .ans_data(ans_data), .ans_valid(ans_valid),
      .ans_error(ans_error), .ans_last(ans_last), .ans_ready(ans_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
   tcf_exec_model exec (.clock(clock), .reset_n(reset_n), .cmd_go(cmd_go),
      .ans_ready(ans_ready), .ans_data(ans_data), .ans_valid(ans_valid),
      .ans_error(ans_error), .ans_last(ans_last));
   always #2 clock = ~clock;
   // --------------------
   // Shared tasks
   // --------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic expect_str(input string s);
      for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
      q.push_back(CH_CR);
      q.push_back(CH_LF);
   endtask
   // Called at a falling edge; holds each character until taken
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         rx_data  = s[i];
         rx_valid = 1'b1;
         while (rx_ready !== 1'b1) @(negedge clock);
         @(negedge clock);
      end
      rx_valid = 1'b0;
      rx_data  = 8'hff;
   endtask
   task automatic drain;
      for (int k = 0; k < 400 && q.size() > 0; k++) @(negedge clock);
      chk(8'(q.size()), 8'h00);
   endtask
   // --------------------
   // Output watcher
   // --------------------
   always @(posedge clock) begin
      cycles++;
      if (tx_valid && tx_ready) chk(tx_data, q.pop_front());
      if (cmd_valid) begin
         chk({6'h00, cmd_kind}, 8'(kinds[n_cmd] - 8'h30));
         chk(cmd_data, aq.pop_front());
         n_cmd++;
      end
      if (cmd_go) n_go++;
      if (cmd_start) n_start++;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   always @(negedge clock) tx_ready <= ($urandom % 4) != 0;
   // --------------------
   // Main sequence
   // --------------------
   initial begin
      clock    = 1'b0;
      reset_n  = 1'b0;
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b0;
      void'($urandom(10));
      expect_str("[>Ready]");
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      drain();
      for (int i = 0; i < names.len(); i++) aq.push_back(names[i]);
      for (int i = 0; i < 7; i++) begin
         expect_str(resp[i]);
         send(cmds[i]);
         drain();
      end
      // Mid-run reset: announcement again, then one plain command
      reset_n = 1'b0;
      expect_str("[>Ready]");
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      drain();
      expect_str(resp[0]);
      send(cmds[0]);
      drain();
      chk(8'(aq.size()), 8'h00);
      chk(8'(n_cmd), 8'h14);
      chk(8'(n_go), 8'h06);
      chk(8'(n_start), 8'h09);
      report_and_stop();
   end
endmodule
